// ---- hw/vir_pkg.sv ----
// Purpose: Shared constants and types of the vectored interrupt controller
// Assumes: APB register access with 32-bit data and 12-bit byte addresses
// Notes: Two targets, fast (0) and standard (1)
package vir_pkg;
  localparam int NUM_IRQ_DEF = 56;
  localparam int NEST_DEF = 15;
  localparam int PRIO_W = 4;
  localparam int IDX_W = 6;
  localparam int TGT_N = 2;
  localparam logic TGT_FAST = 1'b0;
  localparam logic TGT_STD = 1'b1;
  // Register byte offsets; THR/VEC/EOI/NEST pairs: fast target at +0, standard at +4; RAW/SWSET/SWCLR: bits 31:0 at +0, 55:32 at +4
  localparam logic [11:0] OFS_THR = 12'h000;
  localparam logic [11:0] OFS_VEC = 12'h008;
  localparam logic [11:0] OFS_EOI = 12'h010;
  localparam logic [11:0] OFS_NEST = 12'h018;
  localparam logic [11:0] OFS_RAW = 12'h020;
  localparam logic [11:0] OFS_SWSET = 12'h028;
  localparam logic [11:0] OFS_SWCLR = 12'h030;
  localparam logic [11:0] OFS_CFG = 12'h100;
  // Field positions
  localparam int CFG_PRIO_LSB = 0;
  localparam int CFG_TGT_BIT = 8;
  localparam int CFG_POL_BIT = 16;
  localparam int CFG_SW_BIT = 24;
  localparam int VEC_IDX_LSB = 0;
  localparam int VEC_PRIO_LSB = 8;
  localparam int VEC_VALID_BIT = 31;
  localparam int NEST_OVF_BIT = 8;
  // Reset values
  localparam logic [PRIO_W-1:0] THR_RST = 4'h0;
  typedef logic [PRIO_W-1:0] vir_prio_t;
  typedef struct packed {
    logic swReq;
    logic polLow;
    logic target;
    vir_prio_t prio;
  } vir_cfg_t;
  localparam vir_cfg_t CFG_RST = '{swReq: 1'b0, polLow: 1'b0, target: TGT_FAST, prio: 4'h0};
  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    vir_prio_t prio;
  } vir_vec_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } vir_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } vir_apb_rsp_t;
endpackage : vir_pkg

// ---- hw/vir_prio_pick.sv ----
// Purpose: Picks the highest-priority request above a threshold
// Assumes: Priority 0 means masked
// Notes: Ties go to the lowest index
`timescale 1ns/100ps
`default_nettype none
module vir_prio_pick
  import vir_pkg::*;
#(
  parameter int N = NUM_IRQ_DEF,
  parameter int IW = IDX_W
) (
  input wire logic [N-1:0] req,
  input wire vir_prio_t [N-1:0] prio,
  input wire vir_prio_t thr,
  output logic any,
  output logic [IW-1:0] idx,
  output vir_prio_t best
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    best = thr;
    // Strictly greater keeps the earlier, lower index on a tie
    for (int i = 0; i < N; i++) begin
      if (req[i] && prio[i] != '0 && prio[i] > best) begin
        any = 1'b1;
        idx = IW'(i);
        best = prio[i];
      end
    end
  end
endmodule : vir_prio_pick
`default_nettype wire

// ---- hw/vir_irq_ctrl.sv ----
// Purpose: Vectored interrupt controller with two targets and nesting
// Assumes: Requests synchronous to core_clk; APB slave, no wait states
// Notes: Valid vector read raises the target threshold (sets overflow at full nesting depth); end-of-service restores it
`timescale 1ns/100ps
`default_nettype none
module vir_irq_ctrl
  import vir_pkg::*;
#(
  parameter int NUM_IRQ = NUM_IRQ_DEF,
  parameter int NEST_DEPTH = NEST_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [NUM_IRQ-1:0] irqIn,
  input wire vir_apb_req_t apbReq,
  output vir_apb_rsp_t apbRsp,
  output logic fastInterruptTarget,
  output logic stdInterruptTarget,
  output vir_vec_t fastVec,
  output vir_vec_t stdVec
);
  localparam int DW = $clog2(NEST_DEPTH + 1);

  typedef struct packed {
    vir_cfg_t [NUM_IRQ-1:0] cfg;
    logic [NUM_IRQ-1:0] raw;
    vir_prio_t [TGT_N-1:0] thr;
    vir_prio_t [TGT_N-1:0][NEST_DEPTH-1:0] stk;
    logic [TGT_N-1:0][DW-1:0] depth;
    logic [TGT_N-1:0] ovf;
    vir_vec_t [TGT_N-1:0] vec;
    logic [TGT_N-1:0] irq;
    vir_apb_rsp_t rsp;
    logic [TGT_N-1:0] ackPend;
  } vir_state_t;

  vir_state_t st_reg;
  vir_state_t st_next;

  logic [NUM_IRQ-1:0] rawCalc;
  logic [TGT_N-1:0][NUM_IRQ-1:0] reqTgt;
  vir_prio_t [NUM_IRQ-1:0] prioVec;
  logic [TGT_N-1:0] pickAny;
  logic [TGT_N-1:0][IDX_W-1:0] pickIdx;
  vir_prio_t [TGT_N-1:0] pickPrio;

  // Request conditioning and routing
  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      rawCalc[i] = (irqIn[i] ^ st_reg.cfg[i].polLow) | st_reg.cfg[i].swReq;
      prioVec[i] = st_reg.cfg[i].prio;
      reqTgt[TGT_FAST][i] = st_reg.raw[i] && st_reg.cfg[i].target == TGT_FAST;
      reqTgt[TGT_STD][i] = st_reg.raw[i] && st_reg.cfg[i].target == TGT_STD;
    end
  end

  // One picker per target, each against its own threshold
  for (genvar t = 0; t < TGT_N; t++) begin : g_pick
    vir_prio_pick #(
      .N(NUM_IRQ),
      .IW(IDX_W)
    ) u_pick (
      .req(reqTgt[t]),
      .prio(prioVec),
      .thr(st_reg.thr[t]),
      .any(pickAny[t]),
      .idx(pickIdx[t]),
      .best(pickPrio[t])
    );
  end

  logic setup;
  logic access;
  logic tSel;
  logic [11:0] grp;
  logic [IDX_W-1:0] cIdx;
  logic isCfg;
  logic hit;
  logic [31:0] rdData;

  always_comb begin
    setup = apbReq.psel && !apbReq.penable;
    access = apbReq.psel && apbReq.penable && st_reg.rsp.pready;
    tSel = apbReq.paddr[2];
    grp = {apbReq.paddr[11:3], 3'b000};
    cIdx = apbReq.paddr[7:2];
    isCfg = apbReq.paddr[11:8] == OFS_CFG[11:8] && 32'(cIdx) < NUM_IRQ;
    hit = 1'b1;
    rdData = '0;
    unique case (grp)
      OFS_THR: begin
        rdData = 32'(st_reg.thr[tSel]);
      end
      OFS_VEC: begin
        rdData[VEC_VALID_BIT] = st_reg.vec[tSel].valid;
        rdData[VEC_IDX_LSB +: IDX_W] = st_reg.vec[tSel].idx;
        rdData[VEC_PRIO_LSB +: PRIO_W] = st_reg.vec[tSel].prio;
      end
      OFS_EOI: begin
        rdData = '0;
      end
      OFS_NEST: begin
        rdData = 32'(st_reg.depth[tSel]);
        rdData[NEST_OVF_BIT] = st_reg.ovf[tSel];
      end
      OFS_RAW: begin
        rdData = 32'(st_reg.raw >> (tSel ? 32 : 0));
      end
      OFS_SWSET, OFS_SWCLR: begin
        for (int i = 0; i < NUM_IRQ; i++) begin
          if (i / 32 == int'(tSel)) begin
            rdData[i % 32] = st_reg.cfg[i].swReq;
          end
        end
      end
      default: begin
        if (isCfg) begin
          rdData[CFG_PRIO_LSB +: PRIO_W] = st_reg.cfg[cIdx].prio;
          rdData[CFG_TGT_BIT] = st_reg.cfg[cIdx].target;
          rdData[CFG_POL_BIT] = st_reg.cfg[cIdx].polLow;
          rdData[CFG_SW_BIT] = st_reg.cfg[cIdx].swReq;
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.rsp.pready = 1'b0;
    st_next.rsp.pslverr = 1'b0;
    st_next.ackPend = '0;
    st_next.raw = rawCalc;
    for (int t = 0; t < TGT_N; t++) begin
      st_next.irq[t] = pickAny[t];
      st_next.vec[t].valid = pickAny[t];
      st_next.vec[t].idx = pickAny[t] ? pickIdx[t] : '0;
      st_next.vec[t].prio = pickAny[t] ? pickPrio[t] : '0;
    end

    // Setup cycle: answer is prepared so access completes at once
    if (setup) begin
      st_next.rsp.pready = 1'b1;
      st_next.rsp.pslverr = !hit;
      st_next.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : rdData;
      if (!apbReq.pwrite && grp == OFS_VEC && st_reg.vec[tSel].valid) begin
        st_next.ackPend[tSel] = 1'b1;
      end
    end

    // Valid vector read acknowledges: save threshold, raise it to the vector; at full nesting depth set overflow instead
    if (access && !apbReq.pwrite) begin
      for (int t = 0; t < TGT_N; t++) begin
        if (st_reg.ackPend[t]) begin
          if (32'(st_reg.depth[t]) < NEST_DEPTH) begin
            st_next.stk[t][st_reg.depth[t]] = st_reg.thr[t];
            st_next.depth[t] = st_reg.depth[t] + 1'b1;
            st_next.thr[t] = st_reg.rsp.prdata[VEC_PRIO_LSB +: PRIO_W];
          end else begin
            st_next.ovf[t] = 1'b1;
          end
        end
      end
    end

    if (access && apbReq.pwrite && !st_reg.rsp.pslverr) begin
      unique case (grp)
        OFS_THR: begin
          st_next.thr[tSel] = apbReq.pwdata[PRIO_W-1:0];
        end
        OFS_EOI: begin
          // End of service restores the interrupted level
          if (st_reg.depth[tSel] != '0) begin
            st_next.thr[tSel] = st_reg.stk[tSel][st_reg.depth[tSel] - 1'b1];
            st_next.depth[tSel] = st_reg.depth[tSel] - 1'b1;
          end
        end
        OFS_NEST: begin
          if (apbReq.pwdata[NEST_OVF_BIT]) begin
            st_next.ovf[tSel] = 1'b0;
          end
        end
        OFS_SWSET, OFS_SWCLR: begin
          for (int i = 0; i < NUM_IRQ; i++) begin
            if (i / 32 == int'(tSel) && apbReq.pwdata[i % 32]) begin
              st_next.cfg[i].swReq = grp == OFS_SWSET;
            end
          end
        end
        OFS_VEC, OFS_RAW: begin
          st_next.rsp.pslverr = 1'b0;
        end
        default: begin
          st_next.cfg[cIdx].prio = apbReq.pwdata[CFG_PRIO_LSB +: PRIO_W];
          st_next.cfg[cIdx].target = apbReq.pwdata[CFG_TGT_BIT];
          st_next.cfg[cIdx].polLow = apbReq.pwdata[CFG_POL_BIT];
          st_next.cfg[cIdx].swReq = apbReq.pwdata[CFG_SW_BIT];
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.cfg <= {NUM_IRQ{CFG_RST}};
      st_reg.thr <= {TGT_N{THR_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign apbRsp = st_reg.rsp;
  assign fastInterruptTarget = st_reg.irq[TGT_FAST];
  assign stdInterruptTarget = st_reg.irq[TGT_STD];
  assign fastVec = st_reg.vec[TGT_FAST];
  assign stdVec = st_reg.vec[TGT_STD];

  // Helper copies for checking the vector against its cause
  logic [NUM_IRQ-1:0] rawPrev;
  logic [NUM_IRQ-1:0] tgtPrev;
  vir_prio_t [NUM_IRQ-1:0] prioPrev;

  always_ff @(posedge core_clk) begin
    rawPrev <= st_reg.raw;
    for (int i = 0; i < NUM_IRQ; i++) begin
      tgtPrev[i] <= st_reg.cfg[i].target;
      prioPrev[i] <= st_reg.cfg[i].prio;
    end
  end

  logic [NUM_IRQ-1:0] swNow;
  logic [NUM_IRQ-1:0] polNow;

  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      swNow[i] = st_reg.cfg[i].swReq;
      polNow[i] = st_reg.cfg[i].polLow;
    end
  end

  a_raw_polarity: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $past(rstn) |-> st_reg.raw == ($past(irqIn ^ polNow) | $past(swNow))
  ) else $error("raw request does not follow input and polarity");

  a_sw_request: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (swNow != '0) |=> ((st_reg.raw & $past(swNow)) == $past(swNow))
  ) else $error("software request not seen as active");

  a_fast_thresh: assert property (
    @(posedge core_clk) disable iff (!rstn)
    fastInterruptTarget |-> fastVec.prio > $past(st_reg.thr[TGT_FAST])
  ) else $error("fast output with priority not above threshold");

  a_std_thresh: assert property (
    @(posedge core_clk) disable iff (!rstn)
    stdInterruptTarget |-> stdVec.prio > $past(st_reg.thr[TGT_STD])
  ) else $error("standard output with priority not above threshold");

  a_zero_masked: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (fastVec.valid || stdVec.valid) |-> (fastVec.valid ? fastVec.prio != 4'h0 : stdVec.prio != 4'h0)
  ) else $error("priority zero request produced a vector");

  a_vec_source: assert property (
    @(posedge core_clk) disable iff (!rstn)
    fastVec.valid |-> rawPrev[fastVec.idx] && prioPrev[fastVec.idx] == fastVec.prio
  ) else $error("fast vector names an inactive request");

  a_route_std: assert property (
    @(posedge core_clk) disable iff (!rstn)
    stdVec.valid |-> tgtPrev[stdVec.idx] == TGT_STD && rawPrev[stdVec.idx]
  ) else $error("standard vector names a request routed elsewhere");

  a_out_vector: assert property (
    @(posedge core_clk) disable iff (!rstn)
    fastInterruptTarget == fastVec.valid && stdInterruptTarget == stdVec.valid
  ) else $error("output and vector valid disagree");

  a_nest_raise: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (access && !apbReq.pwrite && st_reg.ackPend[TGT_FAST] && 32'(st_reg.depth[TGT_FAST]) < NEST_DEPTH)
      |=> st_reg.thr[TGT_FAST] == $past(st_reg.rsp.prdata[VEC_PRIO_LSB +: PRIO_W])
        && st_reg.depth[TGT_FAST] == $past(st_reg.depth[TGT_FAST]) + 1'b1
  ) else $error("vector read did not raise fast threshold");

  a_eoi_restore: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (access && apbReq.pwrite && grp == OFS_EOI && tSel == TGT_FAST && st_reg.depth[TGT_FAST] != '0)
      |=> st_reg.thr[TGT_FAST] == $past(st_reg.stk[TGT_FAST][st_reg.depth[TGT_FAST] - 1'b1])
        && st_reg.depth[TGT_FAST] == $past(st_reg.depth[TGT_FAST]) - 1'b1
  ) else $error("end of service did not restore fast threshold");

  // Active request that should have beaten the vector shown
  logic [TGT_N-1:0] betterSeen;

  always_comb begin
    betterSeen = '0;
    for (int t = 0; t < TGT_N; t++) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        if (rawPrev[i] && tgtPrev[i] == t[0]) begin
          if (prioPrev[i] > st_reg.vec[t].prio) begin
            betterSeen[t] = 1'b1;
          end
          if (prioPrev[i] == st_reg.vec[t].prio && IDX_W'(i) < st_reg.vec[t].idx) begin
            betterSeen[t] = 1'b1;
          end
        end
      end
    end
  end

  a_fast_best: assert property (
    @(posedge core_clk) disable iff (!rstn)
    fastVec.valid |-> !betterSeen[TGT_FAST]
  ) else $error("fast vector is not the best active request");

  a_std_best: assert property (
    @(posedge core_clk) disable iff (!rstn)
    stdVec.valid |-> !betterSeen[TGT_STD]
  ) else $error("standard vector is not the best active request");

  a_fast_route: assert property (
    @(posedge core_clk) disable iff (!rstn)
    fastVec.valid |-> tgtPrev[fastVec.idx] == TGT_FAST
  ) else $error("fast vector names a request routed elsewhere");

  a_apb_ready: assert property (
    @(posedge core_clk) disable iff (!rstn)
    setup |=> apbRsp.pready ##1 !apbRsp.pready
  ) else $error("APB ready not a single cycle after setup");

endmodule : vir_irq_ctrl
`default_nettype wire

// ---- test/vir_cpu_model.sv ----
// Purpose: Processor-side model counting interrupt entries per target
// Assumes: Interrupt inputs are levels synchronous to core_clk
// Notes: A rising level counts as one entry
`timescale 1ns/100ps
`default_nettype none
module vir_cpu_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic fastIrq,
  input wire logic stdIrq,
  output logic [15:0] fastCnt,
  output logic [15:0] stdCnt
);
  logic fastPrev;
  logic stdPrev;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fastPrev <= 1'b0;
      stdPrev <= 1'b0;
      fastCnt <= 16'h0000;
      stdCnt <= 16'h0000;
    end else begin
      fastPrev <= fastIrq;
      stdPrev <= stdIrq;
      if (fastIrq && !fastPrev) begin
        fastCnt <= fastCnt + 16'h0001;
      end
      if (stdIrq && !stdPrev) begin
        stdCnt <= stdCnt + 16'h0001;
      end
    end
  end
endmodule : vir_cpu_model
`default_nettype wire

// ---- test/vectored_interrupt_controller_tb.sv ----
// Purpose: Self-checking bench for the interrupt controller
// Assumes: APB answers on its own; outputs follow requests within 3 edges
// Notes: Random config with fixed seed, then software and nesting cases
`timescale 1ns/100ps
`default_nettype none
module vectored_interrupt_controller_tb import vir_pkg::*;;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [55:0] irqIn = '0;
  vir_apb_req_t apbReq = '0;
  vir_apb_rsp_t apbRsp;
  logic fastIrq;
  logic stdIrq;
  vir_vec_t fastVec;
  vir_vec_t stdVec;
  logic [15:0] fastCnt;
  logic [15:0] stdCnt;
  int errorCnt = 0;
  int comparisons = 0;
  vir_prio_t prioM [56];
  logic [55:0] tgtM = '0;
  logic [55:0] polM = '0;
  logic [55:0] swM = '0;
  vir_prio_t thrM [2];
  logic [31:0] rd;
  logic err;
  logic [15:0] fastBase;
  logic [15:0] stdBase;

  vir_irq_ctrl uut (.core_clk(core_clk), .rstn(rstn), .irqIn(irqIn), .apbReq(apbReq), .apbRsp(apbRsp),
    .fastInterruptTarget(fastIrq), .stdInterruptTarget(stdIrq), .fastVec(fastVec), .stdVec(stdVec));
  vir_cpu_model cpu (.core_clk(core_clk), .rstn(rstn), .fastIrq(fastIrq), .stdIrq(stdIrq),
    .fastCnt(fastCnt), .stdCnt(stdCnt));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (apbRsp.pready !== 1'b1);
    chk("pready", 32'h1, 32'(apbRsp.pready));
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask : apb

  task automatic cfg(input int i);
    apb(1'b1, OFS_CFG + 12'(4 * i), {7'h00, swM[i], 7'h00, polM[i], 7'h00, tgtM[i], 4'h0, prioM[i]});
  endtask : cfg

  function automatic vir_vec_t exp_vec(input logic t);
    vir_vec_t v;
    v = '0;
    for (int i = 0; i < 56; i++) begin
      if (((irqIn[i] ^ polM[i]) | swM[i]) && tgtM[i] == t && prioM[i] > thrM[t] && prioM[i] > v.prio) begin
        v = '{valid: 1'b1, idx: 6'(i), prio: prioM[i]};
      end
    end
    return v;
  endfunction : exp_vec

  task automatic chk_outs();
    logic [55:0] raw;
    vir_vec_t ef;
    vir_vec_t es;
    repeat (3) @(posedge core_clk);
    #1;
    raw = (irqIn ^ polM) | swM;
    ef = exp_vec(TGT_FAST);
    es = exp_vec(TGT_STD);
    chk("fastVec", 32'(ef), 32'(fastVec));
    chk("stdVec", 32'(es), 32'(stdVec));
    chk("fastIrq", 32'(ef.valid), 32'(fastIrq));
    chk("stdIrq", 32'(es.valid), 32'(stdIrq));
    apb(1'b0, OFS_RAW, 32'h0);
    chk("raw low", raw[31:0], rd);
    apb(1'b0, OFS_RAW + 12'h004, 32'h0);
    chk("raw high", {8'h00, raw[55:32]}, rd);
  endtask : chk_outs

  task automatic set_thr(input int t, input vir_prio_t v);
    thrM[t] = v;
    apb(1'b1, OFS_THR + 12'(4 * t), 32'(v));
  endtask : set_thr

  initial begin
    repeat (20000) @(posedge core_clk);
    errorCnt++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h2738c7e0));
    prioM = '{default: 4'h0};
    thrM = '{default: 4'h0};
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    apb(1'b0, OFS_CFG + 12'h0DC, 32'h0);
    chk("cfg reset", 32'h0, rd);
    apb(1'b0, OFS_THR + 12'h004, 32'h0);
    chk("thr reset", 32'h0, rd);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    $display("test reset done");
    for (int n = 0; n < 20; n++) begin
      for (int i = 0; i < 56; i++) begin
        prioM[i] = n[0] ? 4'($urandom_range(0, 15)) : 4'($urandom_range(0, 2));
        tgtM[i] = 1'($urandom);
        polM[i] = 1'($urandom);
        cfg(i);
      end
      set_thr(0, 4'($urandom_range(0, 3)));
      set_thr(1, 4'($urandom_range(0, 3)));
      irqIn <= 56'({$urandom, $urandom});
      chk_outs();
    end
    $display("test random done");
    irqIn <= polM;
    prioM[40] = 4'hF;
    tgtM[40] = TGT_STD;
    cfg(40);
    swM[40] = 1'b1;
    apb(1'b1, OFS_SWSET + 12'h004, 32'h100);
    chk_outs();
    swM[40] = 1'b0;
    apb(1'b1, OFS_SWCLR + 12'h004, 32'h100);
    chk_outs();
    $display("test software request done");
    for (int i = 0; i < 56; i++) begin
      prioM[i] = 4'h0;
      tgtM[i] = TGT_FAST;
      cfg(i);
    end
    prioM[3] = 4'h4;
    cfg(3);
    prioM[10] = 4'h9;
    cfg(10);
    set_thr(0, 4'h0);
    fastBase = fastCnt;
    stdBase = stdCnt;
    irqIn <= polM ^ 56'h8;
    chk_outs();
    apb(1'b0, OFS_VEC, 32'h0);
    chk("vector read", {1'b1, 19'h0, 4'h4, 2'h0, 6'h03}, rd);
    thrM[0] = 4'h4;
    chk_outs();
    irqIn <= polM ^ 56'h408;
    chk_outs();
    apb(1'b0, OFS_VEC, 32'h0);
    chk("nested vector", {1'b1, 19'h0, 4'h9, 2'h0, 6'h0A}, rd);
    thrM[0] = 4'h9;
    apb(1'b0, OFS_NEST, 32'h0);
    chk("nest depth", 32'h2, rd & 32'hF);
    apb(1'b1, OFS_EOI, 32'h0);
    thrM[0] = 4'h4;
    chk_outs();
    apb(1'b1, OFS_EOI, 32'h0);
    apb(1'b0, OFS_THR, 32'h0);
    chk("thr restored", 32'h0, rd);
    chk("cpu entries", 32'h3, 32'(fastCnt - fastBase));
    chk("cpu std entries", 32'h0, 32'(stdCnt - stdBase));
    $display("test nesting done");
    complete_run();
  end
endmodule : vectored_interrupt_controller_tb
`default_nettype wire
